/* rtl/cmcs_sequencer.v */
// Conversion sequencer, control registers, result store and alert.
`timescale 1ns/100ps
`include "cmcs_defines.vh"
module cmcs_sequencer #(
  parameter ADC_BITS = 12,
  parameter N_CELLS = 6
) (
  input wire clk_sys, // System clock, 25 MHz.
  input wire reset, // Asynchronous reset, active high.
  input wire conversion_start_pin, // Start pin, active on falling edge.
  input wire sclk_pin, // Serial clock from host.
  input wire cs_n_pin, // Serial chip select, active low.
  input wire sdi_pin, // Serial data in.
  output wire sdo_pin, // Serial data out.
  input wire [ADC_BITS-1:0] adc_code, // Converter code for the selected input.
  output reg [2:0] cell_voltage_inputs_sel, // Cell pair: n picks input n minus n-1.
  output reg [2:0] temperature_inputs_sel, // Temperature input 1 to 6.
  output reg mux_is_temp, // High while a temperature slot runs.
  output reg track_hold_n, // Low while the held sample converts.
  output reg self_test, // High during self-test slots.
  output reg busy, // Sequence in progress.
  output reg alert, // Limit alert.
  output reg [N_CELLS-1:0] balance, // Cell balance drives.
  input wire chain_sdi_hi, // Data from the device above.
  output reg chain_sdo_hi, // Relay of host data up the chain.
  output reg chain_cs_hi, // Relay of chip select up the chain.
  output reg chain_sclk_hi // Relay of serial clock up the chain.
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  localparam ST_IDLE = 4'b0001;
  localparam ST_ACQ = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_STORE = 4'b1000;
  localparam [31:0] CONV_LOAD = `CMCS_CONV_CYC - 1;

  reg [3:0] state_reg;
  reg [15:0] ctrl_reg;
  reg [ADC_BITS-1:0] upper_reg;
  reg [ADC_BITS-1:0] lower_reg;
  reg [ADC_BITS-1:0] result_mem [0:`CMCS_CH_COUNT-1];
  reg [3:0] slot_reg;
  reg [3:0] slot_last_reg;
  reg [3:0] avg_cnt_reg;
  reg [ADC_BITS+2:0] acc_reg;
  reg [7:0] timer_reg;
  reg [1:0] start_sync_reg;
  reg start_last_reg;
  reg [1:0] chain_sync_reg;
  reg [ADC_BITS-1:0] read_word;
  reg [ADC_BITS-1:0] stored_value;
  wire frame_done;
  wire cs_rise;
  wire [23:0] rx_word;
  wire pin_fall;
  wire start_req;
  wire [4:0] rx_addr;
  wire [15:0] rx_data;
  wire [3:0] avg_total;
  wire [7:0] acq_cyc;
  wire [ADC_BITS+2:0] acc_sum;
  wire [N_CELLS*2-1:0] out_of_range;
  integer i;
  wire spi_sdo;
  wire [31:0] acq_full;
  wire [3:0] store_idx;
  reg [2:0] relay_sync_reg;

  // ********************************************************************
  // Serial link
  // ********************************************************************
  cmcs_spi_slave #(
    .FRAME_BITS(24)
  ) u_spi (
    .clk_sys(clk_sys),
    .reset(reset),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .sdi_pin(sdi_pin),
    .tx_word({4'h0, read_word}),
    .sdo(spi_sdo),
    .frame_done(frame_done),
    .cs_rise(cs_rise),
    .rx_word(rx_word)
  );

  // Frame is write flag, 2 spare bits, 5-bit address, 16-bit data.
  assign rx_addr = rx_word[20:16];
  assign rx_data = rx_word[15:0];

  // Read word is whatever address was named in the previous frame.
  reg [4:0] rd_addr_reg;
  always @* begin
    read_word = {ADC_BITS{1'b0}};
    if (rd_addr_reg < `CMCS_CH_COUNT) begin
      read_word = result_mem[rd_addr_reg[3:0]];
    end else if (rd_addr_reg == `CMCS_ADDR_CTRL) begin
      read_word = ctrl_reg[ADC_BITS-1:0];
    end else if (rd_addr_reg == `CMCS_ADDR_UPPER) begin
      read_word = upper_reg;
    end else if (rd_addr_reg == `CMCS_ADDR_LOWER) begin
      read_word = lower_reg;
    end else if (rd_addr_reg == `CMCS_ADDR_BAL) begin
      read_word = {{(ADC_BITS-N_CELLS){1'b0}}, balance};
    end else if (rd_addr_reg == `CMCS_ADDR_STAT) begin
      read_word = {{(ADC_BITS-2){1'b0}}, alert, busy};
    end
  end

  // Host writes; the control word upper nibble is only visible via effect.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `CMCS_CTRL_RESET;
      upper_reg <= `CMCS_UPPER_RESET;
      lower_reg <= `CMCS_LOWER_RESET;
      balance <= {N_CELLS{1'b0}};
      rd_addr_reg <= 5'h00;
    end else if (frame_done) begin
      rd_addr_reg <= rx_addr;
      if (rx_word[23] == `CMCS_CMD_WRITE) begin
        if (rx_addr == `CMCS_ADDR_CTRL) begin
          ctrl_reg <= rx_data;
        end
        if (rx_addr == `CMCS_ADDR_UPPER) begin
          upper_reg <= rx_data[ADC_BITS-1:0];
        end
        if (rx_addr == `CMCS_ADDR_LOWER) begin
          lower_reg <= rx_data[ADC_BITS-1:0];
        end
        if (rx_addr == `CMCS_ADDR_BAL) begin
          balance <= rx_data[N_CELLS-1:0];
        end
      end
    end
  end

  // ********************************************************************
  // Daisy chain relay
  // ********************************************************************
  // Control goes up through two flops like any pin; data from above joins the link.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      relay_sync_reg <= 3'b010;
      chain_sdo_hi <= 1'b0;
      chain_cs_hi <= 1'b1;
      chain_sclk_hi <= 1'b0;
      chain_sync_reg <= 2'b00;
    end else begin
      relay_sync_reg <= {sdi_pin, cs_n_pin, sclk_pin};
      chain_sdo_hi <= relay_sync_reg[2];
      chain_cs_hi <= relay_sync_reg[1];
      chain_sclk_hi <= relay_sync_reg[0];
      chain_sync_reg <= {chain_sync_reg[0], chain_sdi_hi};
    end
  end

  // Silent devices above hold their line low, so a plain OR merges the two.
  assign sdo_pin = spi_sdo | chain_sync_reg[1];

  // ********************************************************************
  // Start detection
  // ********************************************************************
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      start_sync_reg <= 2'b11;
      start_last_reg <= 1'b1;
    end else begin
      start_sync_reg <= {start_sync_reg[0], conversion_start_pin};
      start_last_reg <= start_sync_reg[1];
    end
  end

  assign pin_fall = ~start_sync_reg[1] & start_last_reg;
  // Only one source is live at a time, chosen by the software-start bit.
  assign start_req = ctrl_reg[`CMCS_CTRL_SWST] ? cs_rise : pin_fall;

  // ********************************************************************
  // Timing
  // ********************************************************************
  // Acquisition is one to four steps of 400 ns.
  assign acq_full = (ctrl_reg[`CMCS_CTRL_ACQ_HI:`CMCS_CTRL_ACQ_LO] + 32'd1)
                    * `CMCS_ACQ_STEP_CYC;
  assign acq_cyc = acq_full[7:0];
  // Averaging code 0 means one conversion, then 2, 4, 8.
  assign avg_total = 4'h1 << ctrl_reg[`CMCS_CTRL_AVG_HI:`CMCS_CTRL_AVG_LO];
  // Temperature results land by input number, so a short sequence skips registers.
  assign store_idx = mux_is_temp ? 4'd5 + {1'b0, temperature_inputs_sel} : slot_reg;
  assign acc_sum = acc_reg + {3'b000, (self_test ? `CMCS_SELF_CODE : adc_code)};

  // Last slot index depends on the sequence field.
  always @* begin
    case (ctrl_reg[`CMCS_CTRL_SEQ_HI:`CMCS_CTRL_SEQ_LO])
      `CMCS_SEQ_ALL: slot_last_reg = 4'd11;
      `CMCS_SEQ_HALF_T: slot_last_reg = 4'd8;
      default: slot_last_reg = 4'd5;
    endcase
  end

  // Averaged value; a power-of-two shift keeps the 12-bit format.
  always @* begin
    case (ctrl_reg[`CMCS_CTRL_AVG_HI:`CMCS_CTRL_AVG_LO])
      2'd1: stored_value = acc_sum[ADC_BITS:1];
      2'd2: stored_value = acc_sum[ADC_BITS+1:2];
      2'd3: stored_value = acc_sum[ADC_BITS+2:3];
      default: stored_value = acc_sum[ADC_BITS-1:0];
    endcase
  end

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  // Each slot after the first: acquisition then conversion, together at least 1 us; the first slot goes straight to conversion.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      slot_reg <= 4'h0;
      avg_cnt_reg <= 4'h0;
      acc_reg <= {(ADC_BITS+3){1'b0}};
      timer_reg <= 8'h00;
      busy <= 1'b0;
      track_hold_n <= 1'b1;
      cell_voltage_inputs_sel <= 3'd6;
      temperature_inputs_sel <= 3'd1;
      mux_is_temp <= 1'b0;
      self_test <= 1'b0;
      for (i = 0; i < `CMCS_CH_COUNT; i = i + 1) begin
        result_mem[i] <= {ADC_BITS{1'b0}};
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Starts during a sequence are dropped, not queued.
          if (start_req) begin
            busy <= 1'b1;
            slot_reg <= 4'h0;
            avg_cnt_reg <= 4'h0;
            acc_reg <= {(ADC_BITS+3){1'b0}};
            self_test <= (ctrl_reg[`CMCS_CTRL_SEQ_HI:`CMCS_CTRL_SEQ_LO] == `CMCS_SEQ_SELF);
            track_hold_n <= 1'b0;
            timer_reg <= CONV_LOAD[7:0];
            state_reg <= ST_CONV;
          end
        end
        ST_ACQ: begin
          if (timer_reg == 8'h00) begin
            track_hold_n <= 1'b0;
            timer_reg <= CONV_LOAD[7:0];
            state_reg <= ST_CONV;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_CONV: begin
          if (timer_reg == 8'h00) begin
            state_reg <= ST_STORE;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_STORE: begin
          track_hold_n <= 1'b1;
          if (avg_cnt_reg + 4'h1 < avg_total) begin
            acc_reg <= acc_sum;
            avg_cnt_reg <= avg_cnt_reg + 4'h1;
          end else begin
            result_mem[store_idx] <= stored_value;
            acc_reg <= {(ADC_BITS+3){1'b0}};
            avg_cnt_reg <= 4'h0;
            if (slot_reg == slot_last_reg) begin
              slot_reg <= 4'h0;
              cell_voltage_inputs_sel <= 3'd6;
              mux_is_temp <= 1'b0;
              temperature_inputs_sel <= 3'd1;
              self_test <= 1'b0;
            end else begin
              slot_reg <= slot_reg + 4'h1;
              if (slot_reg < 4'd5) begin
                cell_voltage_inputs_sel <= cell_voltage_inputs_sel - 3'd1;
              end else begin
                mux_is_temp <= 1'b1;
                if (slot_reg != 4'd5) begin
                  temperature_inputs_sel <= temperature_inputs_sel +
                    ((ctrl_reg[`CMCS_CTRL_SEQ_HI:`CMCS_CTRL_SEQ_LO] == `CMCS_SEQ_HALF_T)
                     ? 3'd2 : 3'd1);
                end
              end
            end
          end
          if (avg_cnt_reg + 4'h1 >= avg_total && slot_reg == slot_last_reg) begin
            busy <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= acq_cyc - 8'h01;
            state_reg <= ST_ACQ;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ********************************************************************
  // Alert
  // ********************************************************************
  // Voltage and temperature slots share one pair of thresholds.
  genvar g;
  generate
    for (g = 0; g < N_CELLS * 2; g = g + 1) begin : g_lim
      assign out_of_range[g] = (result_mem[g] > upper_reg) | (result_mem[g] < lower_reg);
    end
  endgenerate

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alert <= 1'b0;
    end else begin
      alert <= |out_of_range;
    end
  end

endmodule // cmcs_sequencer

/* rtl/cmcs_defines.vh */
// Constants of the cell monitor conversion sequencer.
// How it works
// - One start launches the whole programmed sequence, up to twelve channels.
// - Chip select rising edge starts the sequence when software start selected.
// - After reset the start pin is the start source until control selects serial.
// - Default sequence converts six voltages then six temperatures.
// - Sequence field also offers six voltages plus three temperatures, or voltages only.
// - Each channel result goes into its own result register at conversion end.
// - Each slot lasts at least one microsecond; that is the reset default. Here the first slot skips acquisition and takes only the 600 ns conversion.
// - A control field lengthens acquisition, extending every slot after the first.
// - Averaging takes 2, 4 or 8 conversions per channel and stores the mean.
// - Averaging resets to zero, meaning one conversion per channel.
// - Host reads results and registers over the four wire serial link.
// - Alert is raised when any result is above upper or below lower threshold.
// - Six balance outputs follow their register bits.
// - In a chain, data goes down the link and control is relayed up.
// - Voltage channel n is input n minus input n-1, cells one to six.
// - A temperature multiplexer selects one of six inputs per temperature slot.
// - Results are twelve bit straight binary.
// - Voltage span is 1V to 5V, temperature span 0V to 5V.
// - Voltage LSB is 976 uV, temperature LSB 1.22 mV, over 4096 codes.
// - Start pin falling edge starts the first conversion; each end starts the next.
// - Sequence codes: 00 all, 01 six plus three, 10 voltage only, 11 self test.
// - Acquisition defaults to 400 ns, steps of 400 ns up to 1.6 us.
`ifndef CMCS_DEFINES_VH
`define CMCS_DEFINES_VH
`define CMCS_CLK_MHZ 25
`define CMCS_SLOT_NS 1000
`define CMCS_ACQ_STEP_NS 400
`define CMCS_CONV_NS (`CMCS_SLOT_NS - `CMCS_ACQ_STEP_NS)
`define CMCS_CONV_CYC ((`CMCS_CONV_NS * `CMCS_CLK_MHZ + 999) / 1000)
`define CMCS_ACQ_STEP_CYC ((`CMCS_ACQ_STEP_NS * `CMCS_CLK_MHZ + 999) / 1000)
`define CMCS_SEQ_ALL 2'b00
`define CMCS_SEQ_HALF_T 2'b01
`define CMCS_SEQ_V_ONLY 2'b10
`define CMCS_SEQ_SELF 2'b11
`define CMCS_SELF_CODE 12'h800
`define CMCS_CH_COUNT 12
`define CMCS_CTRL_RESET 16'h0000
`define CMCS_CMD_WRITE 1'b1
`define CMCS_ADDR_CTRL 5'h0c
`define CMCS_ADDR_UPPER 5'h0d
`define CMCS_ADDR_LOWER 5'h0e
`define CMCS_ADDR_BAL 5'h0f
`define CMCS_ADDR_STAT 5'h10
`define CMCS_CTRL_SEQ_HI 15
`define CMCS_CTRL_SEQ_LO 14
`define CMCS_CTRL_AVG_HI 13
`define CMCS_CTRL_AVG_LO 12
`define CMCS_CTRL_SWST 7
`define CMCS_CTRL_ACQ_HI 6
`define CMCS_CTRL_ACQ_LO 5
`define CMCS_UPPER_RESET 12'hfff
`define CMCS_LOWER_RESET 12'h000
`endif

/* rtl/cmcs_spi_slave.v */
// Serial slave: samples the four-wire link and frames 24-bit words.
`timescale 1ns/100ps
module cmcs_spi_slave #(
  parameter FRAME_BITS = 24
) (
  input wire clk_sys, // System clock.
  input wire reset, // Asynchronous reset, active high.
  input wire sclk_pin, // Serial clock from the host.
  input wire cs_n_pin, // Chip select from the host, active low.
  input wire sdi_pin, // Serial data from the host.
  input wire [15:0] tx_word, // Word shifted out during a read frame.
  output reg sdo, // Serial data to the host.
  output reg frame_done, // Pulse: a full frame was received.
  output reg cs_rise, // Pulse: chip select went high.
  output reg [FRAME_BITS-1:0] rx_word // Last frame received.
);

  // ********************************************************************
  // Synchronisers
  // ********************************************************************
  reg [1:0] sclk_sync_reg;
  reg [1:0] cs_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg sclk_last_reg;
  reg cs_last_reg;
  reg [FRAME_BITS-1:0] shift_reg;
  reg [4:0] count_reg;
  reg [15:0] tx_shift_reg;
  wire sclk_rise;
  wire sclk_fall;

  // Pins are foreign to clk_sys, so each passes two flops first.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclk_sync_reg <= 2'b00;
      cs_sync_reg <= 2'b11;
      sdi_sync_reg <= 2'b00;
      sclk_last_reg <= 1'b0;
      cs_last_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      sdi_sync_reg <= {sdi_sync_reg[0], sdi_pin};
      sclk_last_reg <= sclk_sync_reg[1];
      cs_last_reg <= cs_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_last_reg;

  // ********************************************************************
  // Framing
  // ********************************************************************
  // Data is taken on sclk rise and driven on sclk fall, mode 0 style.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_reg <= {FRAME_BITS{1'b0}};
      count_reg <= 5'h00;
      tx_shift_reg <= 16'h0000;
      sdo <= 1'b0;
      frame_done <= 1'b0;
      cs_rise <= 1'b0;
      rx_word <= {FRAME_BITS{1'b0}};
    end else begin
      frame_done <= 1'b0;
      cs_rise <= cs_sync_reg[1] & ~cs_last_reg;
      if (cs_sync_reg[1]) begin
        count_reg <= 5'h00;
        tx_shift_reg <= tx_word;
        sdo <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_sync_reg[1]};
        if (count_reg == FRAME_BITS - 1) begin
          count_reg <= 5'h00;
          frame_done <= 1'b1;
          rx_word <= {shift_reg[FRAME_BITS-2:0], sdi_sync_reg[1]};
          tx_shift_reg <= tx_word;
        end else begin
          count_reg <= count_reg + 5'h01;
        end
      end else if (sclk_fall) begin
        sdo <= tx_shift_reg[15];
        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
      end
    end
  end

endmodule // cmcs_spi_slave

/* sim/cmcs_checker.sv */
// Port assertions for the conversion sequencer, bound to its top module.
`timescale 1ns/100ps
module cmcs_checker (
  input wire clk_sys, // System clock.
  input wire reset, // Asynchronous reset, active high.
  input wire cs_n_pin, // Chip select from the host.
  input wire [2:0] cell_voltage_inputs_sel, // Cell pair select.
  input wire [2:0] temperature_inputs_sel, // Temperature input select.
  input wire mux_is_temp, // Temperature slot flag.
  input wire track_hold_n, // Low while converting.
  input wire self_test, // Self-test slot flag.
  input wire busy, // Sequence running.
  input wire alert, // Limit alert.
  input wire chain_cs_hi // Relayed chip select.
);
  // ************
  // Properties
  // ************
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_hold_in_seq;
    $fell(track_hold_n) |-> busy;
  endproperty
  a_hold_in_seq: assert property (p_hold_in_seq) else $error("hold outside a sequence");
  property p_start_conv;
    $rose(busy) |-> ##[0:4] !track_hold_n;
  endproperty
  a_start_conv: assert property (p_start_conv) else $error("start did not convert");
  property p_conv_len;
    $fell(track_hold_n) |-> !track_hold_n [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");
  // Acquisition follows each change of cell pair, so tracking must last.
  property p_acq_len;
    $changed(cell_voltage_inputs_sel) && busy |-> track_hold_n [*6];
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition too short");
  property p_hold_stable;
    !track_hold_n && !$past(track_hold_n) |-> $stable(cell_voltage_inputs_sel) &&
      $stable(temperature_inputs_sel) && $stable(mux_is_temp);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("mux moved in hold");
  property p_cell_step;
    $changed(cell_voltage_inputs_sel) && cell_voltage_inputs_sel != 3'd6 |->
      cell_voltage_inputs_sel == $past(cell_voltage_inputs_sel) - 3'd1;
  endproperty
  a_cell_step: assert property (p_cell_step) else $error("cell order broken");
  property p_home;
    $fell(busy) |-> ##[0:2] (cell_voltage_inputs_sel == 3'd6 && !mux_is_temp);
  endproperty
  a_home: assert property (p_home) else $error("mux not back at top cell");
  property p_temp_first;
    $rose(mux_is_temp) |-> temperature_inputs_sel == 3'd1;
  endproperty
  a_temp_first: assert property (p_temp_first) else $error("first temp not input 1");
  property p_self_busy;
    self_test |-> busy;
  endproperty
  a_self_busy: assert property (p_self_busy) else $error("self test while idle");
  property p_relay_cs;
    $rose(cs_n_pin) |-> ##[1:3] chain_cs_hi;
  endproperty
  a_relay_cs: assert property (p_relay_cs) else $error("chip select not relayed");
  c_run: cover property ($rose(busy));
  c_temp: cover property ($rose(mux_is_temp));
  c_alert: cover property ($rose(alert));
endmodule // cmcs_checker
bind cmcs_sequencer cmcs_checker chk (.clk_sys(clk_sys), .reset(reset), .cs_n_pin(cs_n_pin),
  .cell_voltage_inputs_sel(cell_voltage_inputs_sel),
  .temperature_inputs_sel(temperature_inputs_sel), .mux_is_temp(mux_is_temp),
  .track_hold_n(track_hold_n), .self_test(self_test), .busy(busy), .alert(alert),
  .chain_cs_hi(chain_cs_hi));

/* sim/cmcs_host_model.sv */
// Host model: serial master that frames 24-bit words to the monitor.
`timescale 1ns/100ps
module cmcs_host_model (
  output reg sclk, // Serial clock, still between frames.
  output reg cs_n, // Chip select, active low.
  output reg sdi, // Serial data to the device.
  input wire sdo // Serial data from the device.
);
  // ************
  // Link master
  // ************
  localparam int HALF = 160;
  // Pin changes sit off the system clock edges, so the device never races them.
  localparam int SKEW = 10;
  // The link idles with the clock low and chip select high.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Data moves on the fall, both ends sample on the rise.
  task automatic xfer(input logic [23:0] word, output logic [15:0] rdat);
    integer i;
    #SKEW;
    cs_n = 1'b0;
    for (i = 23; i >= 0; i--) begin
      sdi = word[i];
      #HALF sclk = 1'b1;
      // The device shifts its first bit out on the first fall, one clock late.
      if (i <= 22 && i >= 7) rdat[i-7] = sdo;
      #HALF sclk = 1'b0;
    end
    // Data after the frame is not held, so it shows the inverse.
    #HALF sdi = ~sdi;
    cs_n = 1'b1;
    #(4 * HALF - SKEW);
  endtask
endmodule // cmcs_host_model

/* sim/testbench.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/100ps
`include "cmcs_defines.vh"
module testbench;
  // ************
  // Signals and instances
  // ************
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg conversion_start_pin = 1'b1;
  reg [11:0] adc_code = 12'h000;
  reg chain_in = 1'b0;
  reg [11:0] adc_off = 12'h100;
  reg [11:0] last_off [0:11];
  reg [1:0] seqs [0:2] = '{2'b00, 2'b10, 2'b01};
  integer nsl [0:2] = '{12, 6, 9};
  reg [15:0] rd;
  wire sclk_pin, cs_n_pin, sdi_pin, sdo_pin, mux_is_temp, track_hold_n, self_test, busy, alert;
  wire chain_sdo_hi, chain_cs_hi, chain_sclk_hi;
  wire [2:0] cell_sel, temp_sel;
  wire [5:0] balance;
  integer num_errors = 0;
  integer checks_done = 0;
  integer cyc, dur0, a, k;
  cmcs_host_model host (.sclk(sclk_pin), .cs_n(cs_n_pin), .sdi(sdi_pin), .sdo(sdo_pin));
  cmcs_sequencer uut (.clk_sys(clk_sys), .reset(reset), .conversion_start_pin(conversion_start_pin),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .sdi_pin(sdi_pin), .sdo_pin(sdo_pin),
    .adc_code(adc_code), .cell_voltage_inputs_sel(cell_sel), .temperature_inputs_sel(temp_sel),
    .mux_is_temp(mux_is_temp), .track_hold_n(track_hold_n), .self_test(self_test), .busy(busy),
    .alert(alert), .balance(balance), .chain_sdi_hi(chain_in), .chain_sdo_hi(chain_sdo_hi),
    .chain_cs_hi(chain_cs_hi), .chain_sclk_hi(chain_sclk_hi));
  // A 25 MHz system clock.
  always #20 clk_sys = ~clk_sys;
  // Converter stand-in: each input gives its own code, so a misfiled result shows.
  always @(posedge clk_sys) begin
    adc_code <= mux_is_temp ? adc_off + 12'h100 + {9'h0, temp_sel} : adc_off + {5'h0, cell_sel, 4'h0};
  end
  // ************
  // Tasks
  // ************
  // Slots 0 to 5 hold cells 6 down to 1, slots 6 to 11 temperatures 1 to 6.
  function automatic [11:0] exp_code(input integer ch, input [11:0] off);
    exp_code = (ch < 6) ? off + 12'((6 - ch) * 16) : off + 12'h100 + 12'(ch - 5);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input [4:0] ad, input [15:0] d);
    logic [15:0] nul;
    host.xfer({1'b1, 2'b00, ad, d}, nul);
  endtask
  // The reply to a read arrives in the frame after the one that named it.
  task automatic reg_read(input [4:0] ad, output [15:0] d);
    host.xfer({3'b000, ad, 16'h0000}, d);
    host.xfer({3'b000, `CMCS_ADDR_STAT, 16'h0000}, d);
  endtask
  task automatic wait_idle;
    integer n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      stop_test;
    end
  endtask
  // Pin start, with a second start in mid-run that must change nothing.
  task automatic run_pin(output integer c);
    integer n;
    @(posedge clk_sys) conversion_start_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    conversion_start_pin <= 1'b1;
    n = 0;
    c = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    while (busy === 1'b1 && c < 8000) begin
      @(posedge clk_sys);
      c++;
      if (c == 40) conversion_start_pin <= 1'b0;
      if (c == 43) conversion_start_pin <= 1'b1;
    end
    repeat (30) @(posedge clk_sys);
    check({15'h0, busy}, 16'h0000);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ************
  // Tests
  // ************
  // Cuts a hang short well beyond the expected run time.
  initial begin
    #(2_000_000);
    num_errors++;
    stop_test;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({10'h0, balance}, 16'h0000);
    check({14'h0, busy, alert}, 16'h0000);
    reg_read(`CMCS_ADDR_CTRL, rd);
    check(rd, `CMCS_CTRL_RESET);
    reg_read(`CMCS_ADDR_UPPER, rd);
    check(rd, {4'h0, `CMCS_UPPER_RESET});
    // Sequence codes 00, 10 and 01, each with a fresh offset; untouched results keep the old one.
    for (k = 0; k < 3; k++) begin
      adc_off = 12'h100 + 12'(k * 256);
      reg_write(`CMCS_ADDR_CTRL, {seqs[k], 14'h0000});
      run_pin(cyc);
      if (k == 0) dur0 = cyc;
      // The first slot acquired while idle, so a run is one acquisition short.
      check({15'h0, cyc >= 25 * nsl[k] - `CMCS_ACQ_STEP_CYC}, 16'h0001);
      for (a = 0; a < 12; a++) begin
        if (a < 6 || k == 0 || (k == 2 && a % 2 == 0)) last_off[a] = adc_off;
      end
      for (a = 0; a < 12; a++) begin
        reg_read(a[4:0], rd);
        check(rd, {4'h0, exp_code(a, last_off[a])});
      end
    end
    for (k = 1; k < 4; k++) begin
      reg_write(`CMCS_ADDR_CTRL, 16'(k << 5));
      run_pin(cyc);
      check({15'h0, cyc >= 11 * (25 + 10 * k)}, 16'h0001);
    end
    for (k = 1; k < 4; k++) begin
      reg_write(`CMCS_ADDR_CTRL, 16'(k << 12));
      run_pin(cyc);
      check({15'h0, cyc >= dur0 + 180 * ((1 << k) - 1)}, 16'h0001);
      reg_read(5'h00, rd);
      check(rd, {4'h0, exp_code(0, adc_off)});
    end
    reg_write(`CMCS_ADDR_CTRL, {`CMCS_SEQ_SELF, 14'h0000});
    run_pin(cyc);
    reg_read(5'h00, rd);
    check(rd, {4'h0, `CMCS_SELF_CODE});
    reg_write(`CMCS_ADDR_CTRL, 16'h0000);
    reg_write(`CMCS_ADDR_UPPER, 16'h0050);
    check({15'h0, alert}, 16'h0001);
    reg_write(`CMCS_ADDR_UPPER, 16'h0fff);
    check({15'h0, alert}, 16'h0000);
    reg_write(`CMCS_ADDR_LOWER, 16'h0fff);
    check({15'h0, alert}, 16'h0001);
    reg_write(`CMCS_ADDR_LOWER, 16'h0000);
    check({15'h0, alert}, 16'h0000);
    reg_write(`CMCS_ADDR_BAL, 16'h002b);
    check({10'h0, balance}, 16'h002b);
    // Software start: the pin is ignored and the chip select rise after a frame starts the run.
    reg_write(`CMCS_ADDR_CTRL, 16'h0080);
    wait_idle;
    @(posedge clk_sys) conversion_start_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    conversion_start_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check({15'h0, busy}, 16'h0000);
    reg_read(`CMCS_ADDR_STAT, rd);
    check({15'h0, busy}, 16'h0001);
    check(rd, 16'h0001);
    wait_idle;
    reg_write(`CMCS_ADDR_CTRL, 16'h0000);
    wait_idle;
    // Data from the device above reaches the host line while this one is silent.
    chain_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check({15'h0, sdo_pin}, 16'h0001);
    chain_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({15'h0, sdo_pin}, 16'h0000);
    stop_test;
  end
endmodule // testbench
